// >>> hdl/sep_dev.sv
// Purpose: EEPROM serial port end: pin framing, pause, protect, busy.
// Assumes: Pins are asynchronous; sck well below clock_i / 6.
// Notes:   Array contents stay with the user side; bytes pass out.
// Contract
// - Sample serial input on clock rising edges.
// - Change serial output on clock falling edges.
// - Opcode, address, data arrive as one stream.
// - Host supplies serial clock for every bit.
// - Select high holds serial output released.
// - Select high means standby; write cycle continues.
// - Host frames each session with select edges.
// - Protect pin high blocks no writes.
// - Pin low and enable bit refuse status writes.
// - Host pauses with pause low, clock low.
// - Pause keeps transfer state intact.
// - Pause releases serial output; resume drives again.
// - Host ties pause high when unused.
// - Internal write ends within five milliseconds.
// - Host waits one millisecond after power-up.
// - During write cycle only status read accepted.
`timescale 1ns/100ps
module sep_dev #(
   parameter int unsigned WRITE_CYCLE_CYC = sep_pkg::WRITE_CYCLE_CYC
) (
   input  wire logic       clock_i,
   input  wire logic       rst_i,
   sep_if.dev              link,
   output logic            rx_valid_o,
   input  wire logic       rx_ready_i,
   output logic [7:0]      rx_data_o,
   output logic            rx_first_o,
   input  wire logic [7:0] tx_data_i,
   output logic            tx_taken_o,
   output logic [7:0]      status_o,
   output logic            overrun_o
);
   typedef struct packed {
      logic [4:0]          s1;
      logic [4:0]          s2;
      logic                sck_p;
      sep_pkg::sep_dstate_t st;
      logic [2:0]          bitn;
      logic [1:0]          byten;
      logic [7:0]          shin;
      logic [7:0]          opc;
      logic [7:0]          shout;
      logic [7:0]          sr_new;
      logic                load;
      logic                drv;
      logic                so;
      logic                push;
      logic [7:0]          pdata;
      logic                pfirst;
      logic                wel;
      logic                ppe;
      logic [1:0]          bp;
      logic                busy;
      logic [sep_pkg::TIMER_W-1:0] tmr;
      logic                ovf;
      logic                txl;
   } sep_dev_state_t;

   localparam logic [sep_pkg::TIMER_W-1:0] TMR_LOAD =
      sep_pkg::TIMER_W'(WRITE_CYCLE_CYC - sep_pkg::SYNC_LAG_CYC - 1);

   sep_dev_state_t q;
   sep_dev_state_t n;
   logic           buf_ready;
   logic           rise;
   logic           fall;
   logic           sel;
   logic           run;
   logic           wp_lo;
   logic           held;
   logic [7:0]     byte_in;
   logic [7:0]     status;

   // ***************************************************************
   // Pin views after the two-stage synchroniser
   // ***************************************************************
   assign rise    = q.s2[0] & ~q.sck_p;
   assign fall    = ~q.s2[0] & q.sck_p;
   assign sel     = ~q.s2[1];
   assign held    = ~q.s2[3];
   assign wp_lo   = ~q.s2[4];
   assign run     = sel & ~held;
   assign byte_in = {q.shin[6:0], q.s2[2]};

   // Status byte as seen by a status read
   always_comb begin
      status = sep_pkg::BYTE_RST;
      status[sep_pkg::ST_BUSY_POS] = q.busy;
      status[sep_pkg::ST_WEL_POS]  = q.wel;
      status[sep_pkg::ST_BP_HI:sep_pkg::ST_BP_LO] = q.bp;
      status[sep_pkg::ST_PPE_POS]  = q.ppe;
   end

   // ***************************************************************
   // Next state
   // ***************************************************************
   always_comb begin
      n      = q;
      n.push = 1'b0;
      n.txl  = 1'b0;
      n.s1   = {link.wp_n, link.hold_n, link.si, link.cs_n, link.sck};
      n.s2   = q.s1;
      n.sck_p = q.s2[0];

      // Lost word if the buffer could not take the last push
      if (q.push & ~buf_ready) begin
         n.ovf = 1'b1;
      end

      // Write cycle timer runs whether or not the port is selected
      if (q.busy) begin
         if (q.tmr == '0) begin
            n.busy = 1'b0;
            n.wel  = 1'b0;
         end else begin
            n.tmr = q.tmr - 1'b1;
         end
      end

      if (!sel) begin
         // Session end: commit only whole bytes of an accepted command
         if (q.st != sep_pkg::DS_IDLE && q.st != sep_pkg::DS_SKIP &&
             q.bitn == 3'd0) begin
            unique case (q.opc)
               sep_pkg::OPC_WR_ENABLE:  n.wel = 1'b1;
               sep_pkg::OPC_WR_DISABLE: n.wel = 1'b0;
               sep_pkg::OPC_WRITE: begin
                  if (q.wel && q.byten == 2'd3) begin
                     n.busy = 1'b1;
                     n.tmr  = TMR_LOAD;
                  end
               end
               sep_pkg::OPC_STATUS_WR: begin
                  // Pin high never blocks; low with enable bit refuses
                  if (q.wel && q.byten != 2'd0 &&
                      !(q.ppe && wp_lo)) begin
                     n.bp   = q.sr_new[sep_pkg::ST_BP_HI:sep_pkg::ST_BP_LO];
                     n.ppe  = q.sr_new[sep_pkg::ST_PPE_POS];
                     n.busy = 1'b1;
                     n.tmr  = TMR_LOAD;
                  end
               end
               default: ;
            endcase
         end
         // Standby: framing resets, output released
         n.st    = sep_pkg::DS_IDLE;
         n.bitn  = 3'd0;
         n.byten = 2'd0;
         n.load  = 1'b0;
         n.drv   = 1'b0;
      end else begin
         if (q.st == sep_pkg::DS_IDLE) begin
            n.st = sep_pkg::DS_CMD;
         end

         // Input bits on rising sck, one continuous stream
         if (run && rise) begin
            n.shin = byte_in;
            n.bitn = q.bitn + 3'd1;
            if (q.bitn == 3'd7) begin
               unique case (q.st)
                  sep_pkg::DS_CMD: begin
                     n.opc = byte_in;
                     if (q.busy &&
                         byte_in != sep_pkg::STATUS_READ_CMD) begin
                        n.st = sep_pkg::DS_SKIP;
                     end else begin
                        n.st     = sep_pkg::DS_ARG;
                        n.push   = 1'b1;
                        n.pdata  = byte_in;
                        n.pfirst = 1'b1;
                        n.load   = byte_in == sep_pkg::STATUS_READ_CMD;
                     end
                  end
                  sep_pkg::DS_ARG: begin
                     n.push   = 1'b1;
                     n.pdata  = byte_in;
                     n.pfirst = 1'b0;
                     if (q.byten != 2'd3) begin
                        n.byten = q.byten + 2'd1;
                     end
                     if (q.byten == 2'd0) begin
                        n.sr_new = byte_in;
                     end
                     // Data follows the second address byte
                     n.load = (q.opc == sep_pkg::STATUS_READ_CMD) ||
                              (q.opc == sep_pkg::OPC_READ &&
                               q.byten != 2'd0);
                  end
                  sep_pkg::DS_SKIP: ;
                  sep_pkg::DS_IDLE: ;
               endcase
            end
         end

         // Output bits move on falling sck only
         if (run && fall) begin
            if (q.load) begin
               n.shout = (q.opc == sep_pkg::STATUS_READ_CMD) ?
                         status : tx_data_i;
               n.txl   = q.opc != sep_pkg::STATUS_READ_CMD;
               n.so    = n.shout[7];
               n.shout = {n.shout[6:0], 1'b0};
               n.load  = 1'b0;
               n.drv   = 1'b1;
            end else if (q.drv) begin
               n.so    = q.shout[7];
               n.shout = {q.shout[6:0], 1'b0};
            end
         end
      end
   end

   // ***************************************************************
   // State register
   // ***************************************************************
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         q      <= '0;
         q.s1   <= sep_pkg::SYNC_RST;
         q.s2   <= sep_pkg::SYNC_RST;
         q.st   <= sep_pkg::DS_IDLE;
      end else begin
         q <= n;
      end
   end

   // ***************************************************************
   // Outputs
   // ***************************************************************
   // Released while deselected or paused; pause keeps drv for resume
   assign link.so_oe_n = ~(sel & q.drv & ~held);
   assign link.so      = q.so;
   assign tx_taken_o   = q.txl;
   assign status_o     = status;
   assign overrun_o    = q.ovf;

   // Slack for a receiver that stalls briefly between bytes
   sep_buf2 #(
      .W     (9),
      .DEPTH (2)
   ) u_rxbuf (
      .clock_i     (clock_i),
      .rst_i       (rst_i),
      .in_valid_i  (q.push),
      .in_data_i   ({q.pfirst, q.pdata}),
      .in_ready_o  (buf_ready),
      .out_valid_o (rx_valid_o),
      .out_ready_i (rx_ready_i),
      .out_data_o  ({rx_first_o, rx_data_o})
   );
endmodule

// >>> hdl/sep_pkg.sv
// Purpose: Shared constants and types for the serial EEPROM pin port.
// Assumes: 100 MHz system clock on both ends.
// Notes:   Offsets, reset values and cycle counts live only here.
package sep_pkg;

   // ***************************************************************
   // Timing
   // ***************************************************************
   localparam int CLK_HZ                 = 100_000_000;
   localparam int WRITE_CYCLE_TIME_MS    = 5;
   localparam int POWERUP_READ_DELAY_MS  = 1;
   localparam int POWERUP_WRITE_DELAY_MS = 1;
   // Longest time, so it rounds down
   localparam int WRITE_CYCLE_CYC = CLK_HZ / 1000 * WRITE_CYCLE_TIME_MS;
   // Least time, so it rounds up; both delays are equal
   localparam int POWERUP_CYC =
      (CLK_HZ / 1000 * POWERUP_WRITE_DELAY_MS + 999) / 1000 * 1000;
   localparam int SYNC_LAG_CYC  = 3;
   localparam int SCK_HALF_CYC  = 8;
   localparam int TIMER_W       = 19;
   localparam int POWERUP_W     = 17;

   // ***************************************************************
   // Commands and status layout
   // ***************************************************************
   localparam logic [7:0] OPC_WR_ENABLE   = 8'h06;
   localparam logic [7:0] OPC_WR_DISABLE  = 8'h04;
   localparam logic [7:0] STATUS_READ_CMD = 8'h05;
   localparam logic [7:0] OPC_STATUS_WR   = 8'h01;
   localparam logic [7:0] OPC_READ        = 8'h03;
   localparam logic [7:0] OPC_WRITE       = 8'h02;
   localparam int ST_BUSY_POS = 0;
   localparam int ST_WEL_POS  = 1;
   localparam int ST_BP_LO    = 2;
   localparam int ST_BP_HI    = 3;
   localparam int ST_PPE_POS  = 7;

   // ***************************************************************
   // Reset values
   // ***************************************************************
   // Pin order: wp_n, hold_n, si, cs_n, sck; idle levels
   localparam logic [4:0] SYNC_RST  = 5'h1a;
   localparam logic [7:0] BYTE_RST  = 8'h00;

   typedef enum logic [1:0] {
      DS_IDLE = 2'b00,
      DS_CMD  = 2'b01,
      DS_ARG  = 2'b10,
      DS_SKIP = 2'b11
   } sep_dstate_t;

   typedef enum logic [1:0] {
      HS_WAIT  = 2'b00,
      HS_IDLE  = 2'b01,
      HS_SHIFT = 2'b10,
      HS_GAP   = 2'b11
   } sep_hstate_t;

endpackage

// >>> hdl/sep_if.sv
// Purpose: Pin bundle between host controller and EEPROM port.
// Assumes: Serial output is released by a high enable.
// Notes:   A pull-up is modelled on the released output line.
`timescale 1ns/100ps
interface sep_if;
   logic sck;
   logic cs_n;
   logic si;
   logic hold_n;
   logic wp_n;
   logic so;
   logic so_oe_n;
   logic so_line;

   // Released line floats high through the board pull-up
   assign so_line = so_oe_n ? 1'b1 : so;

   modport dev (
      input  sck, cs_n, si, hold_n, wp_n,
      output so, so_oe_n
   );
   modport host (
      output sck, cs_n, si, hold_n, wp_n,
      input  so_line
   );
endinterface

// >>> hdl/sep_buf2.sv
// Purpose: Two-entry valid/ready buffer.
// Assumes: Single clock, both sides same domain.
// Notes:   in_ready_o drops when both entries are held.
`timescale 1ns/100ps
module sep_buf2 #(
   parameter int W     = 9,
   parameter int DEPTH = 2
) (
   input  wire logic         clock_i,
   input  wire logic         rst_i,
   input  wire logic         in_valid_i,
   input  wire logic [W-1:0] in_data_i,
   output logic              in_ready_o,
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic [W-1:0]      out_data_o
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0]           wr;
      logic [AW-1:0]           rd;
      logic [AW:0]             cnt;
   } sep_buf_t;

   sep_buf_t q;
   sep_buf_t n;
   logic     push;
   logic     pop;

   // ***************************************************************
   // Handshakes
   // ***************************************************************
   assign in_ready_o  = q.cnt != (AW+1)'(DEPTH);
   assign out_valid_o = q.cnt != '0;
   assign out_data_o  = q.mem[q.rd];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   // Pointers wrap at the depth
   always_comb begin
      n = q;
      if (push) begin
         n.mem[q.wr] = in_data_i;
         n.wr = (q.wr == AW'(DEPTH-1)) ? '0 : q.wr + 1'b1;
      end
      if (pop) begin
         n.rd = (q.rd == AW'(DEPTH-1)) ? '0 : q.rd + 1'b1;
      end
      n.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end
endmodule

// >>> hdl/sep_host.sv
// Purpose: Host controller end: makes sck, frames sessions, pauses.
// Assumes: Mode (0,0); sck idles low; request bytes on valid/ready, reply bytes on valid only.
// Notes:   No session starts before the power-up delay has passed.
`timescale 1ns/100ps
module sep_host #(
   parameter int unsigned POWERUP_CYC = sep_pkg::POWERUP_CYC
) (
   input  wire logic       clock_i,
   input  wire logic       rst_i,
   sep_if.host             link,
   input  wire logic       req_valid_i,
   input  wire logic [7:0] req_data_i,
   input  wire logic       req_last_i,
   output logic            req_ready_o,
   output logic            rsp_valid_o,
   output logic [7:0]      rsp_data_o,
   input  wire logic       pause_i,
   input  wire logic       wp_n_i,
   output logic            ready_o
);
   typedef struct packed {
      sep_pkg::sep_hstate_t st;
      logic [sep_pkg::POWERUP_W-1:0] pw;
      logic [3:0] div;
      logic       sck;
      logic       cs_n;
      logic       si;
      logic       hold_n;
      logic       wp_n;
      logic       s1;
      logic       s2;
      logic [7:0] sh;
      logic [7:0] rx;
      logic [2:0] bitn;
      logic       last;
      logic       have;
      logic       rv;
      logic [7:0] rd;
   } sep_host_state_t;

   sep_host_state_t q;
   sep_host_state_t n;
   logic            tick;

   // ***************************************************************
   // Clock divider enable and request handshake
   // ***************************************************************
   assign tick = q.div == 4'(sep_pkg::SCK_HALF_CYC - 1);
   assign req_ready_o = (q.st == sep_pkg::HS_IDLE) ||
                        (q.st == sep_pkg::HS_SHIFT && !q.have);

   always_comb begin
      n      = q;
      n.rv   = 1'b0;
      n.div  = tick ? 4'd0 : q.div + 4'd1;
      n.s1   = link.so_line;
      n.s2   = q.s1;
      n.wp_n = wp_n_i;
      if (req_valid_i && req_ready_o) begin
         n.sh   = req_data_i;
         n.si   = req_data_i[7];
         n.last = req_last_i;
         n.have = 1'b1;
      end
      unique case (q.st)
         sep_pkg::HS_WAIT: begin
            // Supply settle time before any operation
            if (q.pw == sep_pkg::POWERUP_W'(POWERUP_CYC - 1)) begin
               n.st = sep_pkg::HS_IDLE;
            end else begin
               n.pw = q.pw + 1'b1;
            end
         end
         sep_pkg::HS_IDLE: begin
            n.hold_n = 1'b1;
            if (req_valid_i) begin
               n.cs_n = 1'b0;
               n.bitn = 3'd0;
               n.st   = sep_pkg::HS_SHIFT;
            end
         end
         sep_pkg::HS_SHIFT: begin
            if (tick && !q.sck) begin
               // Pause pin moves only while sck is low
               n.hold_n = ~pause_i;
               if (q.hold_n && !pause_i && q.have) begin
                  n.sck = 1'b1;
                  n.rx  = {q.rx[6:0], q.s2};
               end
            end else if (tick) begin
               n.sck  = 1'b0;
               n.bitn = q.bitn + 3'd1;
               n.sh   = {q.sh[6:0], 1'b0};
               n.si   = q.sh[6];
               if (q.bitn == 3'd7) begin
                  n.rv   = 1'b1;
                  n.rd   = q.rx;
                  n.have = 1'b0;
                  if (q.last) begin
                     n.st = sep_pkg::HS_GAP;
                  end
               end
            end
         end
         sep_pkg::HS_GAP: begin
            // Raise select one half period after the last fall
            if (tick) begin
               if (!q.cs_n) begin
                  n.cs_n = 1'b1;
               end else begin
                  n.st = sep_pkg::HS_IDLE;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         q        <= '0;
         q.st     <= sep_pkg::HS_WAIT;
         q.cs_n   <= 1'b1;
         q.hold_n <= 1'b1;
         q.wp_n   <= 1'b1;
      end else begin
         q <= n;
      end
   end

   // ***************************************************************
   // Outputs
   // ***************************************************************
   assign link.sck    = q.sck;
   assign link.cs_n   = q.cs_n;
   assign link.si     = q.si;
   assign link.hold_n = q.hold_n;
   assign link.wp_n   = q.wp_n;
   assign rsp_valid_o = q.rv;
   assign rsp_data_o  = q.rd;
   assign ready_o     = q.st != sep_pkg::HS_WAIT;
endmodule

// >>> sim/sep_link_asserts.sv
// Purpose: Pin checks on the link between host and port ends.
// Assumes: Host makes sck in mode (0,0), half period 8 clocks.
// Notes:   Sees the interface lines only.
`timescale 1ns/100ps
module sep_link_asserts (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic si,
   input wire logic hold_n,
   input wire logic so,
   input wire logic so_oe_n
);
   // ******************************
   // Link properties
   // ******************************
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   // Selected, not paused, output driven
   sequence live_s;
      !cs_n && hold_n;
   endsequence
   sequence drive_s;
      live_s ##0 !so_oe_n;
   endsequence

   chk_si_steady_rise: assert property (
      $rose(sck) ##0 live_s |-> $stable(si) ##1 $stable(si))
      else $error("si moved at sck rise");
   chk_so_after_fall: assert property (
      $changed(so) ##0 drive_s |-> !sck && !$past(sck, 2))
      else $error("so moved outside low phase");
   chk_so_stands_high: assert property (
      $rose(sck) ##0 drive_s |=> $stable(so)[*6])
      else $error("so moved in high phase");
   chk_cs_releases: assert property (
      cs_n[*4] |-> so_oe_n)
      else $error("so driven while deselected");
   chk_pause_releases: assert property (
      !hold_n[*4] |-> so_oe_n)
      else $error("so driven while paused");
   chk_pause_sck_low: assert property (
      $changed(hold_n) or !hold_n |-> !sck)
      else $error("pause edge with sck high");
   chk_select_mode0: assert property (
      $fell(cs_n) |-> !sck)
      else $error("select with sck high");
   chk_select_gap: assert property (
      $rose(cs_n) |=> cs_n[*7])
      else $error("deselect gap too short");
   chk_sck_half: assert property (
      $rose(sck) |=> sck[*7])
      else $error("sck high phase short");
   chk_idle_sck_still: assert property (
      cs_n && $past(cs_n) |-> !sck)
      else $error("sck runs outside a frame");
endmodule

// >>> sim/serial_eeprom_spi_pin_behaviour_test.sv
// Purpose: Self-checking bench, host end facing port end.
// Assumes: Short write and power-up counts set below.
// Notes:   Read bytes come from a bench counter on tx_taken.
`timescale 1ns/100ps
module serial_eeprom_spi_pin_behaviour_test;
   // ******************************
   // Bench signals
   // ******************************
   localparam int WCC = 2000;
   localparam int PUC = 20;
   typedef logic [7:0] sep_bq_t [$];
   logic       clock_i   = 1'h0;
   logic       rst_i     = 1'h1;
   logic       req_valid = 1'h0;
   logic       req_last  = 1'h0;
   logic       pause     = 1'h0;
   logic       wp_n      = 1'h1;
   logic       rx_ready  = 1'h1;
   logic [7:0] req_data  = 8'h00;
   logic [7:0] tx_data   = 8'ha5;
   logic       req_ready, rsp_valid, host_ready, rx_valid;
   logic       rx_first, tx_taken, overrun;
   logic [7:0] rsp_data, rx_data, status;
   logic [8:0] rxq[$];
   logic [7:0] rspq[$];
   int         n_errors  = 0;
   int         n_checks  = 0;
   int         cyc       = 0;
   int         t0;

   // Free-running 100 MHz clock
   always #5 clock_i = ~clock_i;

   sep_if lnk ();
   sep_host #(.POWERUP_CYC(PUC)) sep_host_i (
      .clock_i    (clock_i),
      .rst_i      (rst_i),
      .link       (lnk.host),
      .req_valid_i(req_valid),
      .req_data_i (req_data),
      .req_last_i (req_last),
      .req_ready_o(req_ready),
      .rsp_valid_o(rsp_valid),
      .rsp_data_o (rsp_data),
      .pause_i    (pause),
      .wp_n_i     (wp_n),
      .ready_o    (host_ready)
   );
   sep_dev #(.WRITE_CYCLE_CYC(WCC)) sep_dev_i (
      .clock_i    (clock_i),
      .rst_i      (rst_i),
      .link       (lnk.dev),
      .rx_valid_o (rx_valid),
      .rx_ready_i (rx_ready),
      .rx_data_o  (rx_data),
      .rx_first_o (rx_first),
      .tx_data_i  (tx_data),
      .tx_taken_o (tx_taken),
      .status_o   (status),
      .overrun_o  (overrun)
   );
   sep_link_asserts sep_link_asserts_i (
      .clock_i    (clock_i),
      .rst_i      (rst_i),
      .sck        (lnk.sck),
      .cs_n       (lnk.cs_n),
      .si         (lnk.si),
      .hold_n     (lnk.hold_n),
      .so         (lnk.so),
      .so_oe_n    (lnk.so_oe_n)
   );

   // Log both user sides; the read source steps on each take
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (tx_taken)
         tx_data <= tx_data + 8'h11;
      if (rx_valid && rx_ready)
         rxq.push_back({rx_first, rx_data});
      if (rsp_valid)
         rspq.push_back(rsp_data);
   end

   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // One framed session; ends well after deselect so commits land
   task automatic sess(input sep_bq_t b, input bit exp_rx);
      int g;
      rxq.delete();
      rspq.delete();
      @(posedge clock_i);
      foreach (b[i]) begin
         req_valid <= 1'h1;
         req_data  <= b[i];
         req_last  <= (i == b.size() - 1);
         g = 0;
         do begin
            @(negedge clock_i);
            g++;
         end while (req_ready !== 1'h1 && g < 2000);
         chk(9'(g < 2000), 9'h1);
         @(posedge clock_i);
      end
      req_valid <= 1'h0;
      do @(negedge clock_i); while (lnk.cs_n !== 1'h1);
      repeat (24) @(posedge clock_i);
      if (exp_rx) begin
         chk(9'(rxq.size()), 9'(b.size()));
         foreach (b[i])
            chk(rxq[i], {i == 0, b[i]});
      end
   endtask

   // Busy bit bounded wait; running out counts as a mismatch
   task automatic wait_idle();
      int g;
      g = 0;
      // Read between edges so the flag has settled
      do begin
         @(negedge clock_i);
         g++;
      end while (status[sep_pkg::ST_BUSY_POS] !== 1'h0 && g < 3 * WCC);
      chk(9'(g < 3 * WCC), 9'h1);
   endtask

   // Watchdog sized well past the longest expected run
   initial begin
      repeat (40000) @(posedge clock_i);
      n_errors++;
      close_out();
   end

   // Test sequence
   initial begin
      int g;
      repeat (5) @(posedge clock_i);
      rst_i <= 1'h0;
      g = 0;
      // Sampled off the edge; a limit run out fails the window
      while (host_ready !== 1'h1 && g < 1000) begin
         @(negedge clock_i);
         g++;
      end
      chk(9'(g >= PUC && g <= PUC + 2), 9'h1);
      sess('{8'h06}, 1'h1);
      chk(9'(status[sep_pkg::ST_WEL_POS]), 9'h1);
      $display("test write enable done");
      rx_ready <= 1'h0;
      fork
         sess('{8'h02, 8'h00, 8'h10, 8'h3c}, 1'h1);
         begin
            repeat (300) @(posedge clock_i);
            rx_ready <= 1'h1;
         end
      join
      t0 = cyc;
      chk(9'(overrun), 9'h0);
      chk(9'(status[sep_pkg::ST_BUSY_POS]), 9'h1);
      sess('{8'h03, 8'h00, 8'h10, 8'h00}, 1'h0);
      chk(9'(rxq.size()), 9'h0);
      sess('{8'h05, 8'h00}, 1'h0);
      chk(9'(rspq[1]), 9'h03);
      wait_idle();
      chk(9'(cyc - t0 <= WCC), 9'h1);
      chk(9'(status), 9'h00);
      $display("test write and busy done");
      sess('{8'h06}, 1'h1);
      sess('{8'h01, 8'h8c}, 1'h1);
      wait_idle();
      chk(9'(status), 9'h8c);
      wp_n <= 1'h0;
      sess('{8'h06}, 1'h1);
      sess('{8'h01, 8'h00}, 1'h1);
      wait_idle();
      chk(9'(status[7:2]), 9'h23);
      wp_n <= 1'h1;
      sess('{8'h06}, 1'h1);
      sess('{8'h01, 8'h00}, 1'h1);
      wait_idle();
      chk(9'(status), 9'h00);
      $display("test protect pin done");
      fork
         sess('{8'h03, 8'h00, 8'h20, 8'h00, 8'h00}, 1'h0);
         begin
            repeat (450) @(posedge clock_i);
            pause <= 1'h1;
            repeat (200) @(posedge clock_i);
            pause <= 1'h0;
         end
      join
      chk(rxq[0], 9'h103);
      chk(9'(rspq[3]), 9'ha5);
      chk(9'(rspq[4]), 9'hb6);
      $display("test paused read done");
      // Enable, then disable with the receiver stalled: third byte lost
      sess('{8'h06}, 1'h1);
      rx_ready <= 1'h0;
      sess('{8'h04, 8'h00, 8'h00}, 1'h0);
      chk(9'(status[sep_pkg::ST_WEL_POS]), 9'h0);
      chk(9'(overrun), 9'h1);
      chk(9'(rxq.size()), 9'h0);
      rx_ready <= 1'h1;
      repeat (4) @(posedge clock_i);
      chk(9'(rxq.size()), 9'h2);
      chk(rxq[0], 9'h104);
      $display("test overrun done");
      close_out();
   end
endmodule
